// File: hdl/pvl_pkg.sv
package pvl_pkg;

    // special cycle select encodings
    localparam logic [1:0] SPECIAL_OFF  = 2'h0;
    localparam logic [1:0] SPECIAL_RMW  = 2'h1;
    localparam logic [1:0] SPECIAL_LOCK = 2'h2;

    // destination address space codes
    localparam logic [2:0] SPACE_A16 = 3'h0;
    localparam logic [2:0] SPACE_A24 = 3'h1;
    localparam logic [2:0] SPACE_A32 = 3'h2;

    // posted write queue room needed for a new burst: 1 address + 16 data entries
    localparam logic [6:0] QUEUE_ROOM_NEEDED = 7'h11;
    localparam int         QUEUE_LEVEL_W     = 7;

    // widths
    localparam int ADDR_W = 32;
    localparam int AM_W   = 6;

    // reset values
    localparam logic [31:0] ERR_ADDR_RESET = 32'h0000_0000;
    localparam logic [5:0]  ERR_AM_RESET   = 6'h00;

    // target-side sequencer states, gray along idle->wait->done->stop
    typedef enum logic [2:0] {
        PVL_IDLE  = 3'b000,
        PVL_WAIT  = 3'b001,
        PVL_DONE  = 3'b011,
        PVL_STOP  = 3'b010,
        PVL_ABORT = 3'b110
    } pvl_state_t;

endpackage : pvl_pkg

// File: hdl/pvl_err_log.sv
`timescale 1ns/100ps
// error log storage: address, modifier and flags, read data from registers
module pvl_err_log
    import pvl_pkg::*;
(
    input  wire logic              clock,        // system clock
    input  wire logic              resetn,       // async reset, active low
    input  wire logic              log_we,       // capture a posted-write error
    input  wire logic [ADDR_W-1:0] log_addr,     // failing address
    input  wire logic [AM_W-1:0]   log_am,       // failing modifier code
    input  wire logic              log_iack,     // error was in an iack cycle
    input  wire logic              log_clear,    // software clears valid flag
    output logic      [ADDR_W-1:0] err_addr,     // error_address_log
    output logic      [AM_W-1:0]   err_am,       // error_modifier_code
    output logic                   err_iack,     // iack state at error
    output logic                   err_multi,    // more than one error seen
    output logic                   err_valid     // log holds valid content
);

    logic valid_d;
    logic multi_d;

    // capture wins over a clear in the same cycle
    assign valid_d = log_we | (err_valid & ~log_clear);
    assign multi_d = (log_we & err_valid) | (err_multi & ~(log_clear & ~log_we));

    // log registers
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            err_addr  <= ERR_ADDR_RESET;
            err_am    <= ERR_AM_RESET;
            err_iack  <= 1'b0;
            err_multi <= 1'b0;
            err_valid <= 1'b0;
        end
        else
        begin
            if (log_we && !err_valid)
            begin
                err_addr <= log_addr;
                err_am   <= log_am;
                err_iack <= log_iack;
            end
            err_multi <= multi_d;
            err_valid <= valid_d;
        end
    end

endmodule : pvl_err_log

// File: hdl/pvl_target.sv
`timescale 1ns/100ps
module pvl_target
    import pvl_pkg::*;
(
    input  wire logic                     clock,               // system clock
    input  wire logic                     resetn,              // async reset, active low
    // configuration bits
    input  wire logic [1:0]               special_cycle_select,// disabled/rmw/lock
    input  wire logic                     bus_hold_request,    // software holds the bus
    input  wire logic                     release_mode_select, // 0 release_when_done, 1 release_on_request; not read here, tenure follows bus_hold_request alone
    input  wire logic                     hold_irq_enable,     // interrupt enable for granted
    input  wire logic                     berr_pci_enable,     // pci enable for bus error irq
    input  wire logic                     berr_vme_enable,     // bus enable for bus error irq
    input  wire logic                     err_log_clear,       // clears error log valid flag
    input  wire logic                     sta_clear,           // clears signalled abort flag
    // decoded pci access, valid on the address phase
    input  wire logic                     acc_start,           // new target access decoded
    input  wire logic                     acc_write,           // access is a write
    input  wire logic                     acc_register,        // access hits own registers
    input  wire logic                     acc_memory,          // memory command
    input  wire logic                     acc_special,         // address hits the special address
    input  wire logic                     acc_posted,          // image has posted writes on
    input  wire logic [2:0]               acc_space,           // image address space code
    input  wire logic [AM_W-1:0]          acc_am,              // image modifier code
    input  wire logic [1:0]               acc_addr_low,        // address bits 1:0
    input  wire logic [3:0]               acc_byte_en,         // byte enables (ignored for lock)
    input  wire logic                     frame_active,        // frame asserted on the pci bus
    input  wire logic                     data_beat,           // a data phase completed
    // queue and slave-channel state
    input  wire logic [QUEUE_LEVEL_W-1:0] queue_free,          // free posted_write_queue entries
    input  wire logic                     queue_empty,         // posted_write_queue empty
    input  wire logic                     regs_locked,         // slave channel holds registers
    // vme master interface
    input  wire logic                     vme_owned,           // we currently own the bus
    input  wire logic                     vme_done,            // bus cycle finished
    input  wire logic                     vme_berr,            // bus error on the coupled cycle
    input  wire logic                     pw_berr,             // bus error on a posted write
    input  wire logic [ADDR_W-1:0]        pw_addr,             // address of that posted write
    input  wire logic [AM_W-1:0]          pw_am,               // modifier of that posted write
    input  wire logic                     pw_iack,             // posted write was iack cycle
    output logic                          vme_start,           // start coupled bus cycle
    output logic                          vme_lock_cycle,      // cycle is a lock cycle
    output logic [AM_W-1:0]               vme_am,              // modifier for the cycle
    output logic [3:0]                    vme_byte_en,         // byte enables to the bus
    output logic                          vme_keep_tenure,     // do not release the bus
    output logic                          queue_purge,         // purge entries of failed cycle
    // pci termination
    output logic                          pci_trdy,            // target ready
    output logic                          pci_stop,            // stop request
    output logic                          pci_disconnect,      // stop is a disconnect
    output logic                          pci_retry,           // stop is a retry
    output logic                          pci_target_abort,    // stop is a target-abort
    output logic                          discard_data,        // drop write data of a lock
    // status
    output logic                          bus_hold_granted,    // bus held by request bit
    output logic                          signalled_target_abort, // sticky abort status
    output logic                          pci_irq,             // pci interrupt
    output logic                          bus_error_interrupt, // bus-side error interrupt
    output logic [ADDR_W-1:0]             error_address_log,   // failing address
    output logic [AM_W-1:0]               error_modifier_code, // failing modifier code
    output logic                          error_iack,          // iack state at error
    output logic                          error_multiple,      // repeat error flag
    output logic                          error_log_valid      // log contents valid
);

    pvl_state_t state_q, state_d;
    logic       granted_q, granted_d;
    logic       sta_q, sta_d;
    logic       lock_q, lock_d;
    logic       beat_seen_q, beat_seen_d;
    logic       irq_hold_q, irq_hold_d;
    logic       irq_err_q, irq_err_d;
    logic       bus_irq_q, bus_irq_d;
    logic [AM_W-1:0] am_q, am_d;

    // access classification
    wire lock_space  = (acc_space == SPACE_A16) | (acc_space == SPACE_A24)
                     | (acc_space == SPACE_A32);
    wire lock_req    = (special_cycle_select == SPECIAL_LOCK) & acc_special & acc_write
                     & ~acc_posted & lock_space;
    wire coupled     = ~acc_register & ~(acc_write & acc_posted);
    wire posted_new  = ~acc_register & acc_write & acc_posted;
    wire retry_post  = posted_new & (queue_free < QUEUE_ROOM_NEEDED);
    wire retry_coup  = coupled & (~vme_owned | ~queue_empty);
    wire retry_reg   = acc_register & regs_locked;
    wire retry_now   = acc_start & (retry_post | retry_coup | retry_reg);
    // an access seen outside idle is ignored, so the bus is never started twice
    wire idle        = (state_q == PVL_IDLE);
    wire go_coupled  = acc_start & idle & coupled & ~retry_now;
    wire hold_now    = bus_hold_request & vme_owned;

    // disconnect conditions once a beat has moved
    wire disc_reg    = acc_register & frame_active;
    wire disc_coup   = coupled & frame_active;
    wire disc_mem    = acc_memory & frame_active & (acc_addr_low != 2'h0);
    wire disc_need   = disc_reg | disc_coup | disc_mem;

    // sequencer next state
    always_comb
    begin
        state_d     = state_q;
        beat_seen_d = beat_seen_q;
        lock_d      = lock_q;
        am_d        = am_q;
        case (state_q)
            PVL_IDLE:
            begin
                beat_seen_d = 1'b0;
                lock_d      = 1'b0; // a stale lock would force all lanes
                if (retry_now)
                    state_d = PVL_STOP;
                else if (go_coupled)
                begin
                    state_d = PVL_WAIT;
                    lock_d  = lock_req;
                    am_d    = acc_am;
                end
                else if (acc_start)
                    state_d = PVL_DONE;
            end
            PVL_WAIT:
            begin
                if (vme_berr)
                    state_d = PVL_ABORT;
                else if (vme_done)
                    state_d = PVL_DONE;
            end
            PVL_DONE:
            begin
                if (data_beat)
                    beat_seen_d = 1'b1;
                if (!frame_active && (data_beat || beat_seen_q))
                    state_d = PVL_IDLE;
                else if (beat_seen_q && disc_need)
                    state_d = PVL_STOP;
            end
            PVL_STOP, PVL_ABORT:
            begin
                if (!frame_active)
                    state_d = PVL_IDLE;
            end
            default:
                state_d = PVL_IDLE;
        endcase
    end

    // sticky flags: a set in the clearing cycle wins
    assign sta_d      = (state_q == PVL_WAIT && vme_berr) | (sta_q & ~sta_clear);
    assign granted_d  = hold_now;
    assign irq_hold_d = (hold_now & ~granted_q & hold_irq_enable)
                      | (irq_hold_q & hold_irq_enable & granted_q);
    assign irq_err_d  = (pw_berr & berr_pci_enable) | (irq_err_q & ~err_log_clear);
    assign bus_irq_d  = (pw_berr & berr_vme_enable) | (bus_irq_q & ~err_log_clear);

    // state registers
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q     <= PVL_IDLE;
            beat_seen_q <= 1'b0;
            lock_q      <= 1'b0;
            am_q        <= ERR_AM_RESET;
        end
        else
        begin
            state_q     <= state_d;
            beat_seen_q <= beat_seen_d;
            lock_q      <= lock_d;
            am_q        <= am_d;
        end
    end

    // status registers
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            granted_q  <= 1'b0;
            sta_q      <= 1'b0;
            irq_hold_q <= 1'b0;
            irq_err_q  <= 1'b0;
            bus_irq_q  <= 1'b0;
        end
        else
        begin
            granted_q  <= granted_d;
            sta_q      <= sta_d;
            irq_hold_q <= irq_hold_d;
            irq_err_q  <= irq_err_d;
            bus_irq_q  <= bus_irq_d;
        end
    end

    // bus-side outputs; lock cycle carries all lanes, write data is dropped
    assign vme_start       = go_coupled;
    assign vme_lock_cycle  = (state_q == PVL_WAIT) & lock_q;
    assign vme_am          = am_q;
    assign vme_byte_en     = lock_q ? 4'hF : acc_byte_en;
    assign discard_data    = (state_q == PVL_WAIT) & lock_q;
    // tenure kept only for the hold bit; lock alone does not keep the bus
    assign vme_keep_tenure = bus_hold_request;
    assign queue_purge     = pw_berr;

    // pci termination; stop without trdy moves no more data
    assign pci_stop         = (state_q == PVL_STOP) | (state_q == PVL_ABORT);
    assign pci_trdy         = (state_q == PVL_DONE) & ~(beat_seen_q & disc_need);
    assign pci_disconnect   = (state_q == PVL_STOP) & beat_seen_q;
    assign pci_retry        = (state_q == PVL_STOP) & ~beat_seen_q;
    assign pci_target_abort = (state_q == PVL_ABORT);

    assign bus_hold_granted       = granted_q;
    assign signalled_target_abort = sta_q;
    assign pci_irq                = irq_hold_q | irq_err_q;
    assign bus_error_interrupt    = bus_irq_q;

    // error log for posted writes
    pvl_err_log u_log (
        .clock     (clock),
        .resetn    (resetn),
        .log_we    (pw_berr),
        .log_addr  (pw_addr),
        .log_am    (pw_am),
        .log_iack  (pw_iack),
        .log_clear (err_log_clear),
        .err_addr  (error_address_log),
        .err_am    (error_modifier_code),
        .err_iack  (error_iack),
        .err_multi (error_multiple),
        .err_valid (error_log_valid)
    );

    // termination, retry and ownership
    a_stop_holds: assert property (@(posedge clock) disable iff (!resetn)
        pci_stop && frame_active |=> pci_stop)
        else $error("stop dropped while frame asserted");

    a_no_trdy_stop: assert property (@(posedge clock) disable iff (!resetn)
        pci_stop |-> !pci_trdy)
        else $error("trdy with stop");

    a_abort_sets: assert property (@(posedge clock) disable iff (!resetn)
        (state_q == PVL_WAIT && vme_berr) |=> pci_target_abort && signalled_target_abort)
        else $error("bus error did not abort");

    a_retry_post: assert property (@(posedge clock) disable iff (!resetn)
        (state_q == PVL_IDLE && acc_start && posted_new && queue_free < QUEUE_ROOM_NEEDED)
        |=> pci_retry)
        else $error("posted write not retried");

    a_retry_coup: assert property (@(posedge clock) disable iff (!resetn)
        (state_q == PVL_IDLE && acc_start && coupled && !vme_owned) |=> pci_retry)
        else $error("coupled access not retried");

    a_retry_reg: assert property (@(posedge clock) disable iff (!resetn)
        (state_q == PVL_IDLE && acc_start && acc_register && regs_locked) |=> pci_retry)
        else $error("register access not retried");

    a_coupled_wait: assert property (@(posedge clock) disable iff (!resetn)
        (state_q == PVL_WAIT && !vme_done && !vme_berr) |=> !pci_trdy)
        else $error("completed before bus cycle");

    a_grant_irq: assert property (@(posedge clock) disable iff (!resetn)
        $rose(bus_hold_granted) && hold_irq_enable |-> pci_irq)
        else $error("granted rise gave no interrupt");

    a_keep_tenure: assert property (@(posedge clock) disable iff (!resetn)
        bus_hold_request |-> vme_keep_tenure)
        else $error("tenure not kept");

    a_lock_lanes: assert property (@(posedge clock) disable iff (!resetn)
        vme_lock_cycle |-> vme_byte_en == 4'hF)
        else $error("lock lanes not full");

    a_log_valid: assert property (@(posedge clock) disable iff (!resetn)
        pw_berr |=> error_log_valid)
        else $error("log not valid after error");

    // lock cycle shape and attributes
    a_lock_start: assert property (@(posedge clock) disable iff (!resetn)
        vme_start && lock_req |=> vme_lock_cycle)
        else $error("lock request gave no lock cycle");

    a_lock_discard: assert property (@(posedge clock) disable iff (!resetn)
        vme_lock_cycle |-> discard_data)
        else $error("lock write data kept");

    a_lock_am: assert property (@(posedge clock) disable iff (!resetn)
        vme_start |=> vme_am == $past(acc_am))
        else $error("modifier not from image");

    a_lock_posted: assert property (@(posedge clock) disable iff (!resetn)
        idle && acc_start && acc_posted |=> !vme_lock_cycle)
        else $error("lock on posted image");

    a_lock_space: assert property (@(posedge clock) disable iff (!resetn)
        vme_start && !lock_space |=> !vme_lock_cycle)
        else $error("lock outside standard spaces");

    // grant, error reporting and stop forms
    a_grant_follow: assert property (@(posedge clock) disable iff (!resetn)
        hold_now |=> bus_hold_granted)
        else $error("granted not set while held");

    a_err_pci_irq: assert property (@(posedge clock) disable iff (!resetn)
        pw_berr && berr_pci_enable |=> pci_irq)
        else $error("no pci interrupt on error");

    a_err_bus_irq: assert property (@(posedge clock) disable iff (!resetn)
        pw_berr && berr_vme_enable |=> bus_error_interrupt)
        else $error("no bus interrupt on error");

    a_err_purge: assert property (@(posedge clock) disable iff (!resetn)
        pw_berr |-> queue_purge)
        else $error("entries not purged");

    a_retry_form: assert property (@(posedge clock) disable iff (!resetn)
        pci_retry |-> pci_stop && !pci_trdy)
        else $error("retry without stop");

    a_abort_form: assert property (@(posedge clock) disable iff (!resetn)
        pci_target_abort |-> pci_stop && !pci_trdy)
        else $error("abort without stop");

endmodule : pvl_target

// File: tb/pvl_vme_model.sv
`timescale 1ns/100ps
// far-side bus slave: answers each coupled cycle after a fixed wait
module pvl_vme_model #(
    parameter int DELAY = 3
)(
    input  wire logic clock,     // system clock
    input  wire logic resetn,    // async reset, active low
    input  wire logic vme_start, // coupled cycle request
    input  wire logic give_berr, // answer with a bus error
    output logic      vme_done,  // cycle finished
    output logic      vme_berr   // bus error answer
);
    logic [3:0] cnt_q;

    // slow answer so the target really has to wait in its coupled state
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_q    <= 4'h0;
            vme_done <= 1'b0;
            vme_berr <= 1'b0;
        end
        else
        begin
            cnt_q    <= vme_start ? 4'(DELAY) : ((cnt_q != 4'h0) ? cnt_q - 4'h1 : cnt_q);
            vme_done <= (cnt_q == 4'h1) && !give_berr;
            vme_berr <= (cnt_q == 4'h1) && give_berr;
        end
    end
endmodule : pvl_vme_model

// File: tb/pvl_target_bench.sv
`timescale 1ns/100ps
// bench for the lock and termination logic of the target channel
module pvl_target_bench import pvl_pkg::*;;
    logic        clock, resetn, bus_hold_request, release_mode_select, hold_irq_enable;
    logic        berr_pci_enable, berr_vme_enable, err_log_clear, sta_clear, acc_start;
    logic        acc_write, acc_register, acc_memory, acc_special, acc_posted, frame_active;
    logic        data_beat, queue_empty, regs_locked, vme_owned, vme_done, vme_berr, pw_berr;
    logic        pw_iack, give_berr, vme_start, vme_lock_cycle, vme_keep_tenure, queue_purge;
    logic        pci_trdy, pci_stop, pci_disconnect, pci_retry, pci_target_abort, discard_data;
    logic        bus_hold_granted, signalled_target_abort, pci_irq, bus_error_interrupt;
    logic        error_iack, error_multiple, error_log_valid, st, lk, dd;
    logic [1:0]  special_cycle_select, acc_addr_low;
    logic [2:0]  acc_space;
    logic [3:0]  acc_byte_en, vme_byte_en, be_seen;
    logic [5:0]  acc_am, pw_am, vme_am, error_modifier_code, am_seen;
    logic [6:0]  queue_free;
    logic [31:0] pw_addr, error_address_log;
    logic [2:0]  spc_tab [6] = '{SPACE_A24, SPACE_A16, SPACE_A32, 3'h5, SPACE_A24, SPACE_A24};
    int          err_count, check_count, cyc;

    pvl_target pvl_target_i (.clock(clock), .resetn(resetn),
        .special_cycle_select(special_cycle_select), .bus_hold_request(bus_hold_request),
        .release_mode_select(release_mode_select), .hold_irq_enable(hold_irq_enable),
        .berr_pci_enable(berr_pci_enable), .berr_vme_enable(berr_vme_enable),
        .err_log_clear(err_log_clear), .sta_clear(sta_clear), .acc_start(acc_start),
        .acc_write(acc_write), .acc_register(acc_register), .acc_memory(acc_memory),
        .acc_special(acc_special), .acc_posted(acc_posted), .acc_space(acc_space),
        .acc_am(acc_am), .acc_addr_low(acc_addr_low), .acc_byte_en(acc_byte_en),
        .frame_active(frame_active), .data_beat(data_beat), .queue_free(queue_free),
        .queue_empty(queue_empty), .regs_locked(regs_locked), .vme_owned(vme_owned),
        .vme_done(vme_done), .vme_berr(vme_berr), .pw_berr(pw_berr), .pw_addr(pw_addr),
        .pw_am(pw_am), .pw_iack(pw_iack), .vme_start(vme_start),
        .vme_lock_cycle(vme_lock_cycle), .vme_am(vme_am), .vme_byte_en(vme_byte_en),
        .vme_keep_tenure(vme_keep_tenure), .queue_purge(queue_purge), .pci_trdy(pci_trdy),
        .pci_stop(pci_stop), .pci_disconnect(pci_disconnect), .pci_retry(pci_retry),
        .pci_target_abort(pci_target_abort), .discard_data(discard_data),
        .bus_hold_granted(bus_hold_granted), .signalled_target_abort(signalled_target_abort),
        .pci_irq(pci_irq), .bus_error_interrupt(bus_error_interrupt),
        .error_address_log(error_address_log), .error_modifier_code(error_modifier_code),
        .error_iack(error_iack), .error_multiple(error_multiple),
        .error_log_valid(error_log_valid));
    pvl_vme_model #(.DELAY(3)) pvl_vme_model_i (.clock(clock), .resetn(resetn),
        .vme_start(vme_start), .give_berr(give_berr), .vme_done(vme_done), .vme_berr(vme_berr));

    // one counted comparison; a mismatch is reported at once
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t: seen %0h, expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    // decoded access: start pulse, then wait (bounded) for ready or stop
    task automatic acc(input logic w, r, po, input logic [2:0] spc, input logic [1:0] lo);
        @(negedge clock);
        {acc_write, acc_register, acc_memory, acc_special} = {w, r, !r, !r};
        {acc_posted, acc_space, acc_addr_low} = {po, spc, lo};
        acc_start    = 1'b1;
        frame_active = 1'b1;
        #1 st = vme_start;
        @(negedge clock);
        acc_start = 1'b0;
        {lk, dd, am_seen, be_seen} = {vme_lock_cycle, discard_data, vme_am, vme_byte_en};
        for (int n = 0; n < 20 && pci_trdy !== 1'b1 && pci_stop !== 1'b1; n++)
            @(negedge clock);
    endtask : acc

    // master releases frame; a beat only if the target is ready
    task automatic close();
        @(negedge clock);
        {data_beat, frame_active} = {pci_trdy, 1'b0};
        @(negedge clock);
        data_beat = 1'b0;
        @(negedge clock);
    endtask : close

    // first beat with frame still asserted must end in a disconnect
    task automatic discon();
        @(negedge clock);
        data_beat = 1'b1;
        @(negedge clock);
        data_beat = 1'b0;
        @(negedge clock); // trdy drops first, stop follows a cycle later
        chk({pci_stop, pci_disconnect, pci_trdy}, 3'b110);
        close();
    endtask : discon

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // hang guard: the sequence needs a few hundred cycles at most
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            results();
        end
    end

    initial
    begin
        {resetn, acc_start, frame_active, data_beat, pw_berr, err_log_clear, sta_clear} = '0;
        {bus_hold_request, hold_irq_enable, give_berr, regs_locked, pw_iack} = '0;
        {acc_write, acc_register, acc_memory, acc_special, acc_posted} = '0;
        {release_mode_select, berr_pci_enable, berr_vme_enable, queue_empty, vme_owned} = '1;
        {acc_space, acc_addr_low, pw_am, pw_addr} = '0;
        special_cycle_select = SPECIAL_LOCK;
        queue_free           = QUEUE_ROOM_NEEDED;
        acc_am               = 6'h2D;
        acc_byte_en          = 4'h3;
        repeat (4) @(negedge clock);
        resetn = 1'b1;
        // lock writes per space, non-standard space, posted image, plain read
        for (int i = 0; i < 6; i++)
        begin
            acc(i != 5, 1'b0, i == 4, spc_tab[i], 2'h0);
            chk({lk, dd}, {2{i < 3}});
            chk({st, pci_trdy}, {i != 4, 1'b1});
            if (i < 3)
                chk(be_seen, 4'hF);
            if (i != 4)
                chk(am_seen, acc_am);
            if (i == 0)
                discon();
            else
                close();
        end
        acc(1'b0, 1'b1, 1'b0, SPACE_A24, 2'h0);
        discon();
        acc(1'b1, 1'b0, 1'b1, SPACE_A24, 2'h1);
        discon();
        // no ownership, queue busy, queue one short, registers locked
        for (int i = 0; i < 4; i++)
        begin
            {vme_owned, queue_empty, regs_locked} = {i != 0, i != 1, i == 3};
            queue_free = QUEUE_ROOM_NEEDED - 7'(i == 2);
            acc(i == 2, i == 3, i == 2, SPACE_A24, 2'h0);
            repeat (3) @(negedge clock);
            chk({pci_stop, pci_retry, pci_trdy, st}, 4'b1100);
            close();
            chk(pci_stop, 1'b0);
        end
        {vme_owned, queue_empty, regs_locked, queue_free} = {3'b110, QUEUE_ROOM_NEEDED};
        give_berr = 1'b1;
        acc(1'b0, 1'b0, 1'b0, SPACE_A24, 2'h0);
        chk({pci_stop, pci_target_abort, pci_trdy}, 3'b110);
        close();
        chk(signalled_target_abort, 1'b1);
        {give_berr, sta_clear} = 2'b01;
        @(negedge clock);
        // software ownership: request, wait granted, release, wait cleared
        for (int e = 0; e < 2; e++)
        begin
            {hold_irq_enable, bus_hold_request, sta_clear} = {1'(e), 2'b10};
            #1 chk(vme_keep_tenure, 1'b1);
            for (int n = 0; n < 10 && bus_hold_granted !== 1'b1; n++)
                @(negedge clock);
            chk({bus_hold_granted, pci_irq}, {1'b1, 1'(e)});
            @(negedge clock);
            bus_hold_request = 1'b0;
            for (int n = 0; n < 10 && bus_hold_granted !== 1'b0; n++)
                @(negedge clock);
            @(negedge clock); // the hold interrupt drops one cycle after granted
            chk({bus_hold_granted, vme_keep_tenure, pci_irq}, 3'b000);
        end
        chk(signalled_target_abort, 1'b0);
        // two posted-write errors: first one is kept, second marks a repeat
        for (int i = 0; i < 2; i++)
        begin
            @(negedge clock);
            {pw_berr, pw_iack, pw_am, pw_addr} = {2'b11, 6'h0D + 6'(i), 32'h8000_0040 + 32'(i)};
            #1 chk(queue_purge, 1'b1);
            @(negedge clock);
            pw_berr = 1'b0;
            @(negedge clock);
            chk(error_address_log, 32'h8000_0040);
            chk({error_modifier_code, error_iack, error_multiple}, {6'h0D, 1'b1, 1'(i)});
            chk({error_log_valid, pci_irq, bus_error_interrupt}, 3'b111);
        end
        err_log_clear = 1'b1;
        @(negedge clock);
        err_log_clear = 1'b0;
        @(negedge clock);
        chk({error_log_valid, error_multiple, pci_irq, bus_error_interrupt}, 4'h0);
        results();
    end
endmodule : pvl_target_bench
